/* File: pkg/lsag_defs.svh */
// Constants for the load/store address generator
`ifndef LSAG_DEFS_SVH
`define LSAG_DEFS_SVH
`define LSAG_SP_IDX 4'hd
`define LSAG_PC_IDX 4'hf
`define LSAG_WORD_BYTES 32'h4
`define LSAG_WORD_SHIFT 2
`define LSAG_RST_WORD 32'h0
`define LSAG_RST_MASK 16'h0
`define LSAG_NUM_GPR 15
`endif

/* File: pkg/lsag_pkg.sv */
// Types shared by the load/store address generator
package lsag_pkg;
  typedef enum logic [3:0] {
    LSAG_OP_LOAD = 4'h0,
    LSAG_OP_STORE = 4'h1,
    LSAG_OP_LOAD_MULTIPLE_INC_AFTER = 4'h2,
    LSAG_OP_LOAD_MULTIPLE_DEC_BEFORE = 4'h3,
    LSAG_OP_STORE_MULTIPLE_INC_AFTER = 4'h4,
    LSAG_OP_STORE_MULTIPLE_DEC_BEFORE = 4'h5,
    LSAG_OP_POP = 4'h6,
    LSAG_OP_PUSH = 4'h7,
    LSAG_OP_SUPERVISOR_CALL = 4'h8,
    LSAG_OP_SOFTWARE_BREAKPOINT = 4'h9
  } lsag_op_e;
  typedef enum logic [1:0] {
    LSAG_OFF_IMM = 2'h0,
    LSAG_OFF_REG = 2'h1,
    LSAG_OFF_SCALED = 2'h2
  } lsag_off_e;
  typedef enum logic [1:0] {
    LSAG_IDX_OFFSET = 2'h0,
    LSAG_IDX_PRE = 2'h1,
    LSAG_IDX_POST = 2'h2
  } lsag_idx_e;
  typedef enum logic [3:0] {
    LSAG_ST_IDLE = 4'b0001,
    LSAG_ST_ISSUE = 4'b0010,
    LSAG_ST_WAIT = 4'b0100,
    LSAG_ST_DONE = 4'b1000
  } lsag_state_e;
  typedef struct packed {
    lsag_op_e op;
    logic unpriv;
    logic [3:0] base_idx;
    logic [3:0] rt_idx;
    lsag_off_e off_kind;
    logic [11:0] imm;
    logic [3:0] off_idx;
    logic [4:0] shift;
    logic add;
    lsag_idx_e idx_mode;
    logic wback;
    logic [15:0] reg_list;
  } lsag_cmd_s;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic write;
    logic unpriv;
  } lsag_mem_s;
endpackage

/* File: verilog/lsag_addr_calc.sv */
// Single-access address and base writeback computation
`timescale 1ns/1ps
`default_nettype none
module lsag_addr_calc (
  input wire logic [31:0] base_in,
  input wire logic [31:0] off_reg_in,
  input wire logic [11:0] imm_in,
  input wire logic [4:0] shift_in,
  input wire lsag_pkg::lsag_off_e off_kind_in,
  input wire logic add_in,
  input wire lsag_pkg::lsag_idx_e idx_mode_in,
  output logic [31:0] acc_addr_out,
  output logic [31:0] wb_addr_out,
  output logic wb_en_out
);
  logic [31:0] off_val;
  logic [31:0] moved;

  always_comb begin
    case (off_kind_in)
      lsag_pkg::LSAG_OFF_IMM: off_val = {20'h0, imm_in}; // [R5]
      lsag_pkg::LSAG_OFF_REG: off_val = off_reg_in; // [R6]
      lsag_pkg::LSAG_OFF_SCALED: off_val = off_reg_in << shift_in; // [R7]
      default: off_val = 32'h0;
    endcase
    moved = add_in ? base_in + off_val : base_in - off_val; // [R3]
    case (idx_mode_in)
      lsag_pkg::LSAG_IDX_PRE: begin
        acc_addr_out = moved; // [R9]
        wb_addr_out = moved;
        wb_en_out = 1'b1;
      end
      lsag_pkg::LSAG_IDX_POST: begin
        acc_addr_out = base_in; // [R10]
        wb_addr_out = moved;
        wb_en_out = 1'b1;
      end
      default: begin
        acc_addr_out = moved; // [R8]
        wb_addr_out = base_in;
        wb_en_out = 1'b0; // [R21]
      end
    endcase
  end
endmodule
`default_nettype wire

/* File: verilog/lsag_top.sv */
// Load/store unit address generation and exception sequencing
`timescale 1ns/1ps
`default_nettype none
`include "lsag_defs.svh"
// Notes on behaviour
// R1: Unprivileged variant equals ordinary when unprivileged
// R2: Privileged core issues unprivileged variant unprivileged
// R3: Address is base register combined with offset
// R4: Loads may use aligned PC as base
// R5: Immediate offset is unsigned, added or subtracted
// R6: Register offset, never PC, added or subtracted
// R7: Scaled register offset shifted by immediate first
// R8: Offset mode accesses base plus or minus offset
// R9: Pre-indexed accesses and writes back computed address
// R10: Post-indexed accesses base, writes back computed address
// R11: Multiple transfer moves any register subset
// R12: Multiple transfer uses consecutive aligned words
// R13: Multiple writeback adjusts base by total bytes
// R14: Increment-after and decrement-before for loads and stores
// R15: Pop is increment-after load on SP, writeback
// R16: Push is decrement-before store on SP, writeback
// R17: Loaded PC value becomes interworking branch target
// R18: Supervisor call raises supervisor-call exception
// R19: Breakpoint raises monitor exception or halts core
// R20: Loaded branch target bit zero must be one
// R21: Offset mode leaves base register unchanged
module lsag_top (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic privileged_in,
  input wire logic halt_debug_en_in,
  input wire logic [31:0] pc_in,
  input wire logic cmd_valid_in,
  input wire lsag_pkg::lsag_cmd_s cmd_in,
  output logic cmd_ready_out,
  input wire logic gpr_we_in,
  input wire logic [3:0] gpr_widx_in,
  input wire logic [31:0] gpr_wdata_in,
  input wire logic [3:0] gpr_ridx_in,
  output logic [31:0] gpr_rdata_out,
  output logic mem_valid_out,
  output lsag_pkg::lsag_mem_s mem_out,
  input wire logic mem_ack_in,
  input wire logic [31:0] mem_rdata_in,
  output logic done_out,
  output logic err_out,
  output logic branch_valid_out,
  output logic [31:0] branch_target_out,
  output logic interwork_fault_out,
  output logic sup_call_exc_out,
  output logic [11:0] sup_call_imm_out,
  output logic dbg_monitor_exc_out,
  output logic halt_out
);
  function automatic logic [4:0] count_ones(input logic [15:0] v);
    logic [4:0] n;
    n = 5'h0;
    for (int i = 0; i < 16; i++) begin
      n = n + {4'h0, v[i]};
    end
    return n;
  endfunction

  function automatic logic [3:0] lowest_set(input logic [15:0] v);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        idx = i[3:0];
      end
    end
    return idx;
  endfunction

  function automatic logic [31:0] read_gpr(input logic [31:0] r [0:14],
                                          input logic [3:0] idx,
                                          input logic [31:0] pc);
    logic [31:0] val;
    val = (idx == `LSAG_PC_IDX) ? pc : r[idx];
    return val;
  endfunction

  logic [31:0] regs_ff [0:`LSAG_NUM_GPR-1];
  lsag_pkg::lsag_state_e state_ff;
  lsag_pkg::lsag_cmd_s cmd_ff;
  logic multi_ff;
  logic is_load_ff;
  logic unpriv_ff;
  logic [15:0] mask_ff;
  logic [31:0] addr_ff;
  logic [31:0] wb_val_ff;
  logic wb_en_ff;
  logic [3:0] base_ff;

  logic accept;
  lsag_pkg::lsag_cmd_s eff;
  logic [31:0] pc_aligned;
  logic [31:0] base_val;
  logic [31:0] off_reg_val;
  logic [31:0] one_addr;
  logic [31:0] one_wb;
  logic one_wb_en;
  logic [31:0] total_bytes;
  logic nxt_multi;
  logic nxt_is_load;
  logic nxt_is_db;
  logic nxt_illegal;
  logic nxt_exc;
  logic [3:0] cur_idx;
  logic [15:0] mask_left;
  logic last_beat;

  assign accept = cmd_valid_in && cmd_ready_out;
  // Word-aligned PC used as base for literal loads
  assign pc_aligned = {pc_in[31:`LSAG_WORD_SHIFT], 2'b00};

  // Stack aliases rewritten to their multiple-transfer form
  always_comb begin
    eff = cmd_in;
    case (cmd_in.op)
      lsag_pkg::LSAG_OP_POP: begin
        eff.op = lsag_pkg::LSAG_OP_LOAD_MULTIPLE_INC_AFTER; // [R15]
        eff.base_idx = `LSAG_SP_IDX;
        eff.wback = 1'b1;
      end
      lsag_pkg::LSAG_OP_PUSH: begin
        eff.op = lsag_pkg::LSAG_OP_STORE_MULTIPLE_DEC_BEFORE; // [R16]
        eff.base_idx = `LSAG_SP_IDX;
        eff.wback = 1'b1;
      end
      default: begin
        eff = cmd_in;
      end
    endcase
  end

  always_comb begin
    nxt_multi = 1'b0;
    nxt_is_load = 1'b0;
    nxt_is_db = 1'b0;
    nxt_exc = 1'b0;
    case (eff.op)
      lsag_pkg::LSAG_OP_LOAD: nxt_is_load = 1'b1;
      lsag_pkg::LSAG_OP_STORE: nxt_is_load = 1'b0;
      lsag_pkg::LSAG_OP_LOAD_MULTIPLE_INC_AFTER: begin
        nxt_multi = 1'b1;
        nxt_is_load = 1'b1;
      end
      lsag_pkg::LSAG_OP_LOAD_MULTIPLE_DEC_BEFORE: begin
        nxt_multi = 1'b1;
        nxt_is_load = 1'b1;
        nxt_is_db = 1'b1;
      end
      lsag_pkg::LSAG_OP_STORE_MULTIPLE_INC_AFTER: nxt_multi = 1'b1;
      lsag_pkg::LSAG_OP_STORE_MULTIPLE_DEC_BEFORE: begin
        nxt_multi = 1'b1;
        nxt_is_db = 1'b1;
      end
      default: nxt_exc = 1'b1;
    endcase
  end

  // PC as base only for single loads; PC never an offset register
  always_comb begin
    nxt_illegal = 1'b0;
    if (!nxt_exc) begin
      if (eff.base_idx == `LSAG_PC_IDX && !(nxt_is_load && !nxt_multi)) begin
        nxt_illegal = 1'b1; // [R4]
      end
      if (!nxt_multi && eff.off_kind != lsag_pkg::LSAG_OFF_IMM
          && eff.off_idx == `LSAG_PC_IDX) begin
        nxt_illegal = 1'b1; // [R6] [R7]
      end
      if (nxt_multi && eff.reg_list == `LSAG_RST_MASK) begin
        nxt_illegal = 1'b1;
      end
    end
  end

  assign base_val = read_gpr(regs_ff, eff.base_idx, pc_aligned); // [R3] [R4]
  assign off_reg_val = read_gpr(regs_ff, eff.off_idx, pc_aligned);
  assign total_bytes = {25'h0, count_ones(eff.reg_list), 2'b00}; // [R13]

  lsag_addr_calc u_calc (
    .base_in(base_val),
    .off_reg_in(off_reg_val),
    .imm_in(eff.imm),
    .shift_in(eff.shift),
    .off_kind_in(eff.off_kind),
    .add_in(eff.add),
    .idx_mode_in(eff.idx_mode),
    .acc_addr_out(one_addr),
    .wb_addr_out(one_wb),
    .wb_en_out(one_wb_en)
  );

  assign cur_idx = multi_ff ? lowest_set(mask_ff) : cmd_ff.rt_idx;
  assign mask_left = mask_ff & ~(16'h1 << cur_idx);
  assign last_beat = !multi_ff || (mask_left == `LSAG_RST_MASK);

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state_ff <= lsag_pkg::LSAG_ST_IDLE;
    end else begin
      case (state_ff)
        lsag_pkg::LSAG_ST_IDLE: begin
          if (accept) begin
            state_ff <= (nxt_exc || nxt_illegal) ? lsag_pkg::LSAG_ST_DONE
                                                 : lsag_pkg::LSAG_ST_ISSUE;
          end
        end
        lsag_pkg::LSAG_ST_ISSUE: state_ff <= lsag_pkg::LSAG_ST_WAIT;
        lsag_pkg::LSAG_ST_WAIT: begin
          if (mem_ack_in) begin
            state_ff <= last_beat ? lsag_pkg::LSAG_ST_DONE
                                  : lsag_pkg::LSAG_ST_ISSUE;
          end
        end
        lsag_pkg::LSAG_ST_DONE: state_ff <= lsag_pkg::LSAG_ST_IDLE;
        default: state_ff <= lsag_pkg::LSAG_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      cmd_ready_out <= 1'b1;
    end else if (accept) begin
      cmd_ready_out <= 1'b0;
    end else if (state_ff == lsag_pkg::LSAG_ST_DONE) begin
      cmd_ready_out <= 1'b1;
    end
  end

  // Transfer context captured at acceptance; mask and address then step on each ack
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      cmd_ff <= '0;
      multi_ff <= 1'b0;
      is_load_ff <= 1'b0;
      unpriv_ff <= 1'b0;
      mask_ff <= `LSAG_RST_MASK;
      addr_ff <= `LSAG_RST_WORD;
      wb_val_ff <= `LSAG_RST_WORD;
      wb_en_ff <= 1'b0;
      base_ff <= 4'h0;
    end else if (accept) begin
      cmd_ff <= eff;
      multi_ff <= nxt_multi;
      is_load_ff <= nxt_is_load;
      // Privileged core still presents the unprivileged variant as unprivileged
      unpriv_ff <= eff.unpriv || !privileged_in; // [R1] [R2]
      mask_ff <= eff.reg_list; // [R11]
      base_ff <= eff.base_idx;
      if (nxt_multi) begin
        addr_ff <= nxt_is_db ? base_val - total_bytes : base_val; // [R14]
        wb_val_ff <= nxt_is_db ? base_val - total_bytes
                               : base_val + total_bytes; // [R13]
        // Loaded base value wins over writeback
        wb_en_ff <= eff.wback && !(nxt_is_load && eff.reg_list[eff.base_idx]);
      end else begin
        addr_ff <= one_addr; // [R8] [R9] [R10]
        wb_val_ff <= one_wb;
        // Exception commands carry junk addressing fields, so they never write back
        wb_en_ff <= one_wb_en && !nxt_exc; // [R21]
      end
    end else if (state_ff == lsag_pkg::LSAG_ST_WAIT && mem_ack_in) begin
      mask_ff <= mask_left;
      addr_ff <= addr_ff + `LSAG_WORD_BYTES; // [R12]
    end
  end

  // Memory request held until the memory system acknowledges
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      mem_valid_out <= 1'b0;
      mem_out <= '0;
    end else if (state_ff == lsag_pkg::LSAG_ST_ISSUE) begin
      mem_valid_out <= 1'b1;
      mem_out.addr <= addr_ff;
      mem_out.wdata <= read_gpr(regs_ff, cur_idx, pc_in);
      mem_out.write <= !is_load_ff;
      mem_out.unpriv <= unpriv_ff; // [R2]
    end else if (mem_ack_in) begin
      mem_valid_out <= 1'b0;
    end
  end

  // Register file: one write per cycle by construction
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      for (int i = 0; i < `LSAG_NUM_GPR; i++) begin
        regs_ff[i] <= `LSAG_RST_WORD;
      end
    end else if (state_ff == lsag_pkg::LSAG_ST_WAIT) begin
      if (mem_ack_in && is_load_ff && cur_idx != `LSAG_PC_IDX) begin
        regs_ff[cur_idx] <= mem_rdata_in; // [R11]
      end
    end else if (state_ff == lsag_pkg::LSAG_ST_DONE) begin
      if (wb_en_ff && !err_out) begin
        regs_ff[base_ff] <= wb_val_ff; // [R9] [R10] [R13]
      end
    end else if (state_ff == lsag_pkg::LSAG_ST_IDLE) begin
      if (gpr_we_in && gpr_widx_in != `LSAG_PC_IDX) begin
        regs_ff[gpr_widx_in] <= gpr_wdata_in;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      gpr_rdata_out <= `LSAG_RST_WORD;
    end else begin
      gpr_rdata_out <= read_gpr(regs_ff, gpr_ridx_in, pc_in);
    end
  end

  // A loaded PC value is a branch, bit zero must select the only state
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      branch_valid_out <= 1'b0;
      branch_target_out <= `LSAG_RST_WORD;
      interwork_fault_out <= 1'b0;
    end else begin
      branch_valid_out <= 1'b0;
      interwork_fault_out <= 1'b0;
      if (state_ff == lsag_pkg::LSAG_ST_WAIT && mem_ack_in && is_load_ff
          && cur_idx == `LSAG_PC_IDX) begin
        branch_target_out <= {mem_rdata_in[31:1], 1'b0}; // [R17]
        branch_valid_out <= mem_rdata_in[0]; // [R20]
        interwork_fault_out <= !mem_rdata_in[0]; // [R20]
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      sup_call_exc_out <= 1'b0;
      sup_call_imm_out <= 12'h0;
      dbg_monitor_exc_out <= 1'b0;
      halt_out <= 1'b0;
      err_out <= 1'b0;
    end else begin
      sup_call_exc_out <= 1'b0;
      dbg_monitor_exc_out <= 1'b0;
      halt_out <= 1'b0;
      if (accept) begin
        err_out <= nxt_illegal;
        if (cmd_in.op == lsag_pkg::LSAG_OP_SUPERVISOR_CALL) begin
          sup_call_exc_out <= 1'b1; // [R18]
          sup_call_imm_out <= cmd_in.imm;
        end
        if (cmd_in.op == lsag_pkg::LSAG_OP_SOFTWARE_BREAKPOINT) begin
          // Debug configuration picks halting over the monitor
          halt_out <= halt_debug_en_in; // [R19]
          dbg_monitor_exc_out <= !halt_debug_en_in; // [R19]
        end
        if (nxt_exc && cmd_in.op != lsag_pkg::LSAG_OP_SUPERVISOR_CALL
            && cmd_in.op != lsag_pkg::LSAG_OP_SOFTWARE_BREAKPOINT) begin
          err_out <= 1'b1;
        end
      end else if (state_ff == lsag_pkg::LSAG_ST_DONE) begin
        err_out <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      done_out <= 1'b0;
    end else begin
      done_out <= (state_ff == lsag_pkg::LSAG_ST_DONE);
    end
  end
endmodule
`default_nettype wire

/* File: bench/lsag_checker.sv */
// Concurrent checks on the address generator ports
`timescale 1ns/1ps
`default_nettype none
module lsag_checker (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic privileged_in,
  input wire logic halt_debug_en_in,
  input wire logic [31:0] pc_in,
  input wire logic cmd_valid_in,
  input wire lsag_pkg::lsag_cmd_s cmd_in,
  input wire logic cmd_ready_out,
  input wire logic mem_valid_out,
  input wire lsag_pkg::lsag_mem_s mem_out,
  input wire logic mem_ack_in,
  input wire logic done_out,
  input wire logic err_out,
  input wire logic sup_call_exc_out,
  input wire logic [11:0] sup_call_imm_out,
  input wire logic dbg_monitor_exc_out,
  input wire logic halt_out
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (srst_in);
  logic take;
  logic unpriv_ff;
  logic [31:0] lit_ff;
  assign take = cmd_valid_in && cmd_ready_out;
  // Expectations are frozen at accept, since privilege and pc may move later
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      unpriv_ff <= 1'b0;
      lit_ff <= 32'h0;
    end else if (take) begin
      unpriv_ff <= cmd_in.unpriv | ~privileged_in;
      lit_ff <= {pc_in[31:2], 2'b00} + {20'h0, cmd_in.imm};
    end
  end
  sequence call_take_s;
    take && cmd_in.op == lsag_pkg::LSAG_OP_SUPERVISOR_CALL;
  endsequence
  sequence brk_take_s;
    take && cmd_in.op == lsag_pkg::LSAG_OP_SOFTWARE_BREAKPOINT;
  endsequence
  sequence pcst_take_s;
    take && cmd_in.op == lsag_pkg::LSAG_OP_STORE && cmd_in.base_idx == 4'hf;
  endsequence
  sequence lit_take_s;
    take && cmd_in.op == lsag_pkg::LSAG_OP_LOAD && cmd_in.base_idx == 4'hf && cmd_in.add &&
      cmd_in.off_kind == lsag_pkg::LSAG_OFF_IMM && cmd_in.idx_mode == lsag_pkg::LSAG_IDX_OFFSET;
  endsequence
  mem_hold_a: assert property (mem_valid_out && !mem_ack_in |=> mem_valid_out && $stable(mem_out))
    else $error("memory request changed before ack");
  ack_drop_a: assert property (mem_valid_out && mem_ack_in |=> !mem_valid_out)
    else $error("memory request held after ack");
  busy_after_take_a: assert property (take |=> !cmd_ready_out)
    else $error("ready high after accept");
  done_ready_a: assert property (done_out |-> cmd_ready_out ##1 !done_out)
    else $error("done pulse or ready wrong");
  unpriv_level_a: assert property (mem_valid_out |-> mem_out.unpriv == unpriv_ff)
    else $error("access privilege flag wrong");
  literal_addr_a: assert property (lit_take_s |-> ##2 mem_valid_out && mem_out.addr == lit_ff)
    else $error("literal load address wrong");
  pc_store_refused_a: assert property (pcst_take_s |=> err_out && !mem_valid_out ##1 done_out && !mem_valid_out)
    else $error("store with pc base not refused");
  call_raise_a: assert property (call_take_s |=> sup_call_exc_out &&
    sup_call_imm_out == $past(cmd_in.imm) ##1 done_out)
    else $error("supervisor call not raised");
  brk_route_a: assert property (brk_take_s |=> halt_out == $past(halt_debug_en_in) &&
    dbg_monitor_exc_out != $past(halt_debug_en_in) ##1 done_out)
    else $error("breakpoint routed wrongly");
endmodule
bind lsag_top lsag_checker chk_u (.clk_in, .srst_in, .privileged_in, .halt_debug_en_in, .pc_in,
  .cmd_valid_in, .cmd_in, .cmd_ready_out, .mem_valid_out, .mem_out, .mem_ack_in, .done_out, .err_out,
  .sup_call_exc_out, .sup_call_imm_out, .dbg_monitor_exc_out, .halt_out);
`default_nettype wire

/* File: bench/lsag_mem_model.sv */
// Behavioural data memory answering the generator's requests
`timescale 1ns/1ps
`default_nettype none
module lsag_mem_model (
  input wire logic clk_in,
  input wire logic [3:0] lat_in,
  input wire logic valid_in,
  input wire lsag_pkg::lsag_mem_s req_in,
  output logic ack_out,
  output logic [31:0] rdata_out
);
  logic [31:0] mem [logic [31:0]];
  lsag_pkg::lsag_mem_s log_q[$];
  logic [3:0] wait_ff;
  initial begin
    ack_out = 1'b0;
    rdata_out = 32'h0;
    wait_ff = 4'h0;
  end
  // Read data toggles outside the ack so a stale value is never mistaken for an answer
  always @(posedge clk_in) begin
    if (ack_out || !valid_in) begin
      ack_out <= 1'b0;
      wait_ff <= 4'h0;
      rdata_out <= ~rdata_out;
    end else if (wait_ff >= lat_in) begin
      ack_out <= 1'b1;
      log_q.push_back(req_in);
      if (req_in.write) mem[req_in.addr] = req_in.wdata;
      rdata_out <= mem.exists(req_in.addr) ? mem[req_in.addr] : ~req_in.addr;
    end else begin
      wait_ff <= wait_ff + 4'h1;
      rdata_out <= ~rdata_out;
    end
  end
endmodule
`default_nettype wire

/* File: bench/tb_load_store_address_gen.sv */
// Self-checking bench for the load/store address generator
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_load_store_address_gen;
  logic clk_in, srst_in, privileged_in, halt_debug_en_in, cmd_valid_in, cmd_ready_out, gpr_we_in;
  logic mem_valid_out, mem_ack_in, done_out, err_out, branch_valid_out, interwork_fault_out;
  logic sup_call_exc_out, dbg_monitor_exc_out, halt_out;
  logic [3:0] gpr_widx_in, gpr_ridx_in, lat;
  logic [11:0] sup_call_imm_out;
  logic [31:0] pc_in, gpr_wdata_in, gpr_rdata_out, mem_rdata_in, branch_target_out, br_t;
  lsag_pkg::lsag_cmd_s cmd_in;
  lsag_pkg::lsag_mem_s mem_out;
  int err_count, n_checks, c_err, c_br, c_iw, c_call, c_mon, c_halt, n0;
  lsag_top dut_u (.clk_in, .srst_in, .privileged_in, .halt_debug_en_in, .pc_in, .cmd_valid_in, .cmd_in,
    .cmd_ready_out, .gpr_we_in, .gpr_widx_in, .gpr_wdata_in, .gpr_ridx_in, .gpr_rdata_out, .mem_valid_out,
    .mem_out, .mem_ack_in, .mem_rdata_in, .done_out, .err_out, .branch_valid_out, .branch_target_out,
    .interwork_fault_out, .sup_call_exc_out, .sup_call_imm_out, .dbg_monitor_exc_out, .halt_out);
  lsag_mem_model mem_u (.clk_in(clk_in), .lat_in(lat), .valid_in(mem_valid_out), .req_in(mem_out),
    .ack_out(mem_ack_in), .rdata_out(mem_rdata_in));
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  // Pulses are counted at the falling edge, clear of the edge that launches them
  always @(negedge clk_in) begin
    if (err_out === 1'b1) c_err++;
    if (branch_valid_out === 1'b1) begin
      c_br++;
      br_t = branch_target_out;
    end
    if (interwork_fault_out === 1'b1) c_iw++;
    if (sup_call_exc_out === 1'b1) c_call++;
    if (dbg_monitor_exc_out === 1'b1) c_mon++;
    if (halt_out === 1'b1) c_halt++;
  end
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  function automatic lsag_pkg::lsag_cmd_s mk(input lsag_pkg::lsag_op_e op, input logic [3:0] b, input logic [3:0] t);
    mk = '0;
    mk.op = op;
    mk.base_idx = b;
    mk.rt_idx = t;
    mk.add = 1'b1;
  endfunction
  task automatic wr_gpr(input logic [3:0] i, input logic [31:0] v);
    @(negedge clk_in);
    gpr_we_in = 1'b1;
    gpr_widx_in = i;
    gpr_wdata_in = v;
    @(negedge clk_in);
    gpr_we_in = 1'b0;
  endtask
  task automatic chk_gpr(input logic [3:0] i, input logic [31:0] v);
    @(negedge clk_in);
    gpr_ridx_in = i;
    @(negedge clk_in);
    `CHK(gpr_rdata_out, v)
  endtask
  task automatic chk_acc(input int i, input logic [31:0] a, input logic w);
    `CHK(mem_u.log_q[n0 + i].addr, a)
    `CHK(mem_u.log_q[n0 + i].write, w)
  endtask
  // Both waits share one bound so a stuck handshake ends the run instead of hanging it
  task automatic run(input lsag_pkg::lsag_cmd_s c);
    int k;
    k = 0;
    {c_err, c_br, c_iw, c_call, c_mon, c_halt} = '0;
    n0 = mem_u.log_q.size();
    @(negedge clk_in);
    cmd_in = c;
    cmd_valid_in = 1'b1;
    while (cmd_ready_out !== 1'b1 && k < 100) begin
      @(negedge clk_in);
      k++;
    end
    @(negedge clk_in);
    cmd_valid_in = 1'b0;
    while (done_out !== 1'b1 && k < 100) begin
      @(negedge clk_in);
      k++;
    end
    if (k >= 100) begin
      err_count++;
      stop_test();
    end
  endtask
  task automatic t_index();
    lsag_pkg::lsag_cmd_s c;
    logic [31:0] a;
    for (int i = 0; i < 3; i++) begin
      wr_gpr(4'h1, 32'h1000);
      c = mk(lsag_pkg::LSAG_OP_LOAD, 4'h1, 4'h2);
      c.imm = 12'hfff;
      c.idx_mode = lsag_pkg::lsag_idx_e'(i);
      c.add = (i != 2);
      c.wback = (i != 0);
      run(c);
      a = (i == 2) ? 32'h1000 : 32'h1fff;
      chk_acc(0, a, 1'b0);
      chk_gpr(4'h2, ~a);
      chk_gpr(4'h1, (i == 0) ? 32'h1000 : (i == 1) ? 32'h1fff : 32'h1);
    end
  endtask
  task automatic t_regoff();
    lsag_pkg::lsag_cmd_s c;
    wr_gpr(4'h3, 32'h2000);
    wr_gpr(4'h4, 32'h3);
    wr_gpr(4'h5, 32'h55);
    for (int j = 0; j < 4; j++) begin
      privileged_in = j[1];
      c = mk(lsag_pkg::LSAG_OP_STORE, 4'h3, 4'h5);
      c.unpriv = j[0];
      c.off_idx = 4'h4;
      c.shift = 5'h2;
      c.off_kind = j[0] ? lsag_pkg::LSAG_OFF_SCALED : lsag_pkg::LSAG_OFF_REG;
      c.add = !j[0];
      run(c);
      chk_acc(0, j[0] ? 32'h1ff4 : 32'h2003, 1'b1);
      `CHK(mem_u.log_q[n0].unpriv, j[0] | ~j[1])
      `CHK(mem_u.log_q[n0].wdata, 32'h55)
    end
    privileged_in = 1'b1;
  endtask
  task automatic t_lit();
    lsag_pkg::lsag_cmd_s c;
    pc_in = 32'h8006;
    c = mk(lsag_pkg::LSAG_OP_LOAD, 4'hf, 4'h0);
    c.imm = 12'h8;
    run(c);
    chk_acc(0, 32'h800c, 1'b0);
    c.op = lsag_pkg::LSAG_OP_STORE;
    run(c);
    `CHK(c_err != 0 && mem_u.log_q.size() == n0, 1'b1)
    c = mk(lsag_pkg::LSAG_OP_LOAD, 4'h1, 4'h2);
    c.off_kind = lsag_pkg::LSAG_OFF_REG;
    c.off_idx = 4'hf;
    run(c);
    `CHK(c_err != 0 && mem_u.log_q.size() == n0, 1'b1)
    c = mk(lsag_pkg::LSAG_OP_LOAD_MULTIPLE_INC_AFTER, 4'h6, 4'h0);
    run(c);
    `CHK(c_err != 0 && mem_u.log_q.size() == n0, 1'b1)
  endtask
  task automatic t_multi();
    lsag_pkg::lsag_cmd_s c;
    lsag_pkg::lsag_op_e ops[4] = '{lsag_pkg::LSAG_OP_STORE_MULTIPLE_INC_AFTER,
      lsag_pkg::LSAG_OP_STORE_MULTIPLE_DEC_BEFORE, lsag_pkg::LSAG_OP_LOAD_MULTIPLE_INC_AFTER,
      lsag_pkg::LSAG_OP_LOAD_MULTIPLE_DEC_BEFORE};
    logic [31:0] v[3] = '{32'h11, 32'h22, 32'h77};
    logic [31:0] s;
    lat = 4'h2;
    wr_gpr(4'h1, v[0]);
    wr_gpr(4'h2, v[1]);
    wr_gpr(4'h7, v[2]);
    for (int i = 0; i < 4; i++) begin
      wr_gpr(4'h6, 32'h3000);
      c = mk(ops[i], 4'h6, 4'h0);
      c.wback = 1'b1;
      c.reg_list = (i < 2) ? 16'h0086 : 16'h0700;
      run(c);
      s = i[0] ? 32'h2ff4 : 32'h3000;
      for (int k = 0; k < 3; k++) begin
        chk_acc(k, s + 32'(4 * k), i < 2);
        if (i >= 2) chk_gpr(4'(8 + k), v[k]);
      end
      chk_gpr(4'h6, i[0] ? s : s + 32'hc);
    end
    wr_gpr(4'hd, 32'h4000);
    c = mk(lsag_pkg::LSAG_OP_PUSH, 4'hd, 4'h0);
    c.reg_list = 16'h0006;
    c.wback = 1'b1;
    run(c);
    chk_acc(0, 32'h3ff8, 1'b1);
    chk_acc(1, 32'h3ffc, 1'b1);
    chk_gpr(4'hd, 32'h3ff8);
    c.op = lsag_pkg::LSAG_OP_POP;
    c.reg_list = 16'h1800;
    run(c);
    chk_gpr(4'hb, v[0]);
    chk_gpr(4'hc, v[1]);
    chk_gpr(4'hd, 32'h4000);
    lat = 4'h0;
  endtask
  task automatic t_pop_pc();
    lsag_pkg::lsag_cmd_s c;
    c = mk(lsag_pkg::LSAG_OP_POP, 4'hd, 4'h0);
    c.reg_list = 16'h8000;
    c.wback = 1'b1;
    for (int i = 0; i < 2; i++) begin
      wr_gpr(4'hd, 32'h5000);
      mem_u.mem[32'h5000] = i ? 32'h9000 : 32'h9001;
      run(c);
      `CHK(c_br, 1 - i)
      `CHK(c_iw, i)
      if (i == 0) begin
        `CHK(br_t, 32'h9000)
        chk_gpr(4'hd, 32'h5004);
      end
    end
  endtask
  task automatic t_exc();
    lsag_pkg::lsag_cmd_s c;
    c = mk(lsag_pkg::LSAG_OP_SUPERVISOR_CALL, 4'h0, 4'h0);
    c.imm = 12'habc;
    run(c);
    `CHK(c_call, 1)
    `CHK(sup_call_imm_out, 12'habc)
    c.op = lsag_pkg::LSAG_OP_SOFTWARE_BREAKPOINT;
    for (int h = 0; h < 2; h++) begin
      halt_debug_en_in = h[0];
      run(c);
      `CHK(c_halt, h)
      `CHK(c_mon, 1 - h)
    end
    // An undecoded op is refused and raises no exception
    c.op = lsag_pkg::lsag_op_e'(4'ha);
    run(c);
    `CHK(c_err != 0 && c_call + c_mon + c_halt == 0, 1'b1)
  endtask
  initial begin
    srst_in = 1'b1;
    privileged_in = 1'b1;
    {halt_debug_en_in, cmd_valid_in, gpr_we_in} = 3'h0;
    {gpr_widx_in, gpr_ridx_in, lat} = 12'h0;
    {pc_in, gpr_wdata_in} = 64'h0;
    cmd_in = '0;
    {err_count, n_checks} = 64'h0;
    repeat (10) @(negedge clk_in);
    srst_in = 1'b0;
    t_index();
    t_regoff();
    t_lit();
    t_multi();
    t_pop_pc();
    t_exc();
    stop_test();
  end
endmodule
`default_nettype wire
